// ==== src/ebp_external_bus_port.sv ====
/*
 * external parallel bus port: master accesses, slave register accesses,
 * bank selects, lane extension and three-state control.
 * assumes pins are resolved outside from the _o/_oe/_i triples, and that
 * bus mastership comes from an arbiter outside this block.
 */
module ebp_external_bus_port #(
  parameter int EP_DIV = ebp_pkg::EP_CLK_DIV
) (
  input  wire logic                        ref_clk,
  input  wire logic                        rst,
  // configuration
  input  wire logic                        bus_master,
  input  wire logic [1:0]                  instruction_packing_field,
  input  wire logic                        link0_enable,
  input  wire logic                        link1_enable,
  input  wire logic                        sdram_half_rate,
  input  wire logic                        slave_sync_mode,
  // core side master requests
  input  wire logic                        mst_req,
  output logic                             mst_ready,
  input  wire logic                        mst_write,
  input  wire logic                        mst_sync,
  input  wire logic                        mst_sdram,
  input  wire logic [ebp_pkg::MADDR_W-1:0] mst_addr,
  input  wire logic [ebp_pkg::DATA_W-1:0]  mst_wdata,
  output logic                             mst_done,
  output logic [ebp_pkg::DATA_W-1:0]       mst_rdata,
  output logic                             mst_wide_fetch,
  // register space side for outside masters
  output logic                             iop_req,
  output logic                             iop_write,
  output logic [ebp_pkg::IOP_W-1:0]        iop_addr,
  output logic [ebp_pkg::DATA_W-1:0]       iop_wdata,
  input  wire logic                        iop_ready,
  input  wire logic [ebp_pkg::DATA_W-1:0]  iop_rdata,
  output logic [ebp_pkg::BANKS-1:0]        tracked_bank_n,
  // pins
  output logic [ebp_pkg::ADDR_W-1:0]       external_address_bus_o,
  output logic                             external_address_bus_oe,
  input  wire logic [ebp_pkg::ADDR_W-1:0]  external_address_bus_i,
  output logic [ebp_pkg::DATA_W-1:0]       external_data_bus_o,
  output logic [ebp_pkg::DATA_W-1:0]       external_data_bus_oe,
  input  wire logic [ebp_pkg::DATA_W-1:0]  external_data_bus_i,
  output logic [ebp_pkg::BANKS-1:0]        bank_select_lines_n_o,
  output logic                             bank_select_lines_oe,
  input  wire logic [ebp_pkg::BANKS-1:0]   bank_select_lines_n_i,
  output logic                             rd_n_o,
  output logic                             rd_n_oe,
  input  wire logic                        rd_n_i,
  output logic                             wr_n_o,
  output logic                             wr_n_oe,
  input  wire logic                        wr_n_i,
  output logic                             ack_o,
  output logic                             ack_oe,
  input  wire logic                        ack_i,
  input  wire logic                        suspend_bus_tristate_n
);

  if (EP_DIV < 1 || EP_DIV > 255) begin : g_chk
    $error("EP_DIV out of range");
  end

  ebp_pkg::ebp_mst_state_type mst_state_reg;
  ebp_pkg::ebp_slv_state_type slv_state_reg;
  logic [7:0]                 ep_cnt_reg;
  logic                       half_reg;
  logic                       step_en;
  logic                       suspend_bus_tristate_reg;
  logic                       drive_en;
  logic [ebp_pkg::DATA_W-1:0] lane_mask;
  logic [ebp_pkg::ADDR_W-1:0] addr_reg;
  logic [ebp_pkg::BANKS-1:0]  bank_n_reg;
  logic [ebp_pkg::DATA_W-1:0] wdata_reg;
  logic                       write_reg;
  logic                       sdram_reg;
  logic                       rd_n_reg;
  logic                       wr_n_reg;
  logic                       rd_meta_reg;
  logic                       rd_sync_reg;
  logic                       wr_meta_reg;
  logic                       wr_sync_reg;
  logic                       slv_hit;
  logic [ebp_pkg::DATA_W-1:0] slv_data_reg;
  logic                       slv_rd_reg;
  logic                       slv_sync_reg;

  // ****************************************
  // rate enables
  // ****************************************
  // port-rate divider and half-core-rate toggle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ep_cnt_reg <= 8'h00;
      half_reg   <= 1'b0;
    end else begin
      half_reg <= ~half_reg;
      if (ep_cnt_reg == 8'(EP_DIV - 1)) begin
        ep_cnt_reg <= 8'h00;
      end else begin
        ep_cnt_reg <= ep_cnt_reg + 8'h01;
      end
    end
  end

  // sdram steps at core or half rate, other banks at port rate
  always_comb begin
    if (sdram_reg) begin
      step_en = sdram_half_rate ? half_reg : 1'b1;
    end else begin
      step_en = (ep_cnt_reg == 8'(EP_DIV - 1));
    end
  end

  // ****************************************
  // three-state control and lanes
  // ****************************************
  // suspend takes effect on the following cycle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      suspend_bus_tristate_reg <= 1'b0;
    end else begin
      suspend_bus_tristate_reg <= ~suspend_bus_tristate_n;
    end
  end

  assign drive_en = bus_master & ~suspend_bus_tristate_reg;

  // lower lanes usable only while the matching link port is off
  assign lane_mask = ebp_pkg::UPPER_MASK
                   | (link1_enable ? '0 : ebp_pkg::LANE1_MASK)
                   | (link0_enable ? '0 : ebp_pkg::LANE0_MASK);

  // full-width fetch only with no packing and both lanes free
  assign mst_wide_fetch = (instruction_packing_field == ebp_pkg::IPACK_NOPACK)
                        & ~link0_enable & ~link1_enable;

  // ****************************************
  // master access sequencer
  // ****************************************
  assign mst_ready = (mst_state_reg == ebp_pkg::M_IDLE) & drive_en;

  // address, select and strobes of one word access
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mst_state_reg <= ebp_pkg::M_IDLE;
      addr_reg      <= '0;
      bank_n_reg    <= ebp_pkg::BANK_IDLE_N;
      wdata_reg     <= '0;
      write_reg     <= 1'b0;
      sdram_reg     <= 1'b0;
      rd_n_reg      <= 1'b1;
      wr_n_reg      <= 1'b1;
      mst_done      <= 1'b0;
      mst_rdata     <= '0;
    end else begin
      mst_done <= 1'b0;
      case (mst_state_reg)
        ebp_pkg::M_IDLE: begin
          if (mst_req && mst_ready) begin
            // select and address change on the same edge
            addr_reg      <= mst_addr[ebp_pkg::ADDR_W-1:0];
            bank_n_reg    <= ebp_pkg::bank_decode(mst_addr, mst_sdram);
            wdata_reg     <= mst_wdata & lane_mask;
            write_reg     <= mst_write;
            sdram_reg     <= mst_sdram;
            mst_state_reg <= ebp_pkg::M_SETUP;
          end
        end
        ebp_pkg::M_SETUP: begin
          if (step_en && !suspend_bus_tristate_reg) begin
            rd_n_reg      <= write_reg;
            wr_n_reg      <= ~write_reg;
            mst_state_reg <= ebp_pkg::M_ACCESS;
          end
        end
        ebp_pkg::M_ACCESS: begin
          // acknowledge low holds the access; suspend halts it
          if (step_en && ack_i && !suspend_bus_tristate_reg) begin
            rd_n_reg      <= 1'b1;
            wr_n_reg      <= 1'b1;
            bank_n_reg    <= ebp_pkg::BANK_IDLE_N;
            mst_rdata     <= external_data_bus_i & lane_mask;
            mst_done      <= 1'b1;
            mst_state_reg <= ebp_pkg::M_IDLE;
          end
        end
        default: begin
          mst_state_reg <= ebp_pkg::M_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // slave side: outside master reaches our registers
  // ****************************************
  // strobes from outside are asynchronous: two-stage synchronisers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rd_meta_reg <= 1'b1;
      rd_sync_reg <= 1'b1;
      wr_meta_reg <= 1'b1;
      wr_sync_reg <= 1'b1;
    end else begin
      rd_meta_reg <= rd_n_i;
      rd_sync_reg <= rd_meta_reg;
      wr_meta_reg <= wr_n_i;
      wr_sync_reg <= wr_meta_reg;
    end
  end

  // outside address inside our register space
  assign slv_hit = ~bus_master
                 & (external_address_bus_i[ebp_pkg::ADDR_W-1:ebp_pkg::IOP_W] == '0);

  // one register access per strobe, held until the strobe returns high
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      slv_state_reg <= ebp_pkg::S_IDLE;
      iop_req       <= 1'b0;
      iop_write     <= 1'b0;
      iop_addr      <= '0;
      iop_wdata     <= '0;
      slv_data_reg  <= '0;
      slv_rd_reg    <= 1'b0;
      slv_sync_reg  <= 1'b0;
    end else begin
      iop_req <= 1'b0;
      case (slv_state_reg)
        ebp_pkg::S_IDLE: begin
          if (slv_hit && (!rd_sync_reg || !wr_sync_reg)) begin
            iop_req       <= 1'b1;
            iop_write     <= ~wr_sync_reg;
            iop_addr      <= external_address_bus_i[ebp_pkg::IOP_W-1:0];
            iop_wdata     <= external_data_bus_i & lane_mask;
            slv_rd_reg    <= wr_sync_reg;
            slv_sync_reg  <= slave_sync_mode;
            slv_state_reg <= ebp_pkg::S_WAIT;
          end
        end
        ebp_pkg::S_WAIT: begin
          if (iop_ready) begin
            slv_data_reg  <= iop_rdata & lane_mask;
            slv_state_reg <= ebp_pkg::S_DONE;
          end
        end
        ebp_pkg::S_DONE: begin
          if (rd_sync_reg && wr_sync_reg) begin
            slv_rd_reg    <= 1'b0;
            slv_state_reg <= ebp_pkg::S_IDLE;
          end
        end
        default: begin
          slv_state_reg <= ebp_pkg::S_IDLE;
        end
      endcase
    end
  end

  // non-master keeps a copy of the master's selects
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tracked_bank_n <= ebp_pkg::BANK_IDLE_N;
    end else if (!bus_master) begin
      tracked_bank_n <= bank_select_lines_n_i;
    end
  end

  // ****************************************
  // pin drivers
  // ****************************************
  assign external_address_bus_o  = addr_reg;
  assign external_address_bus_oe = drive_en;
  assign bank_select_lines_n_o   = bank_n_reg;
  assign bank_select_lines_oe    = drive_en;
  assign rd_n_o                  = rd_n_reg;
  assign rd_n_oe                 = drive_en;
  assign wr_n_o                  = wr_n_reg;
  assign wr_n_oe                 = drive_en;

  // data: master write, or answer to an outside read once ready
  always_comb begin
    external_data_bus_o  = wdata_reg;
    external_data_bus_oe = '0;
    if (drive_en && write_reg && mst_state_reg != ebp_pkg::M_IDLE) begin
      external_data_bus_oe = lane_mask;
    end else if (slv_rd_reg && slv_state_reg == ebp_pkg::S_DONE && !suspend_bus_tristate_reg) begin
      external_data_bus_o  = slv_data_reg;
      external_data_bus_oe = lane_mask;
    end
  end

  // wait states for a synchronous register access still pending
  assign ack_o  = 1'b0;
  assign ack_oe = slv_sync_reg & (slv_state_reg == ebp_pkg::S_WAIT);

  // ****************************************
  // assertions
  // ****************************************
  sequence s_taken;
    mst_state_reg == ebp_pkg::M_IDLE && mst_req && mst_ready;
  endsequence

  sequence s_finish;
    mst_state_reg == ebp_pkg::M_ACCESS && step_en && ack_i && !suspend_bus_tristate_reg;
  endsequence

  a_slave_floats: assert property (@(posedge ref_clk) disable iff (rst)
    !bus_master |-> !external_address_bus_oe && !rd_n_oe && !wr_n_oe && !bank_select_lines_oe)
    else $error("slave drives the bus");

  a_suspend_floats: assert property (@(posedge ref_clk) disable iff (rst)
    !suspend_bus_tristate_n |=> !external_address_bus_oe && !rd_n_oe)
    else $error("bus driven during suspend");

  a_take_addr: assert property (@(posedge ref_clk) disable iff (rst)
    s_taken |=> external_address_bus_o == $past(mst_addr[ebp_pkg::ADDR_W-1:0])
      && bank_select_lines_n_o == ebp_pkg::bank_decode($past(mst_addr), $past(mst_sdram)))
    else $error("address or select not taken together");

  a_strobe_bank: assert property (@(posedge ref_clk) disable iff (rst)
    (!rd_n_reg || !wr_n_reg) |-> bank_n_reg != ebp_pkg::BANK_IDLE_N && (rd_n_reg != wr_n_reg))
    else $error("strobe without bank select");

  a_ack_holds: assert property (@(posedge ref_clk) disable iff (rst)
    mst_state_reg == ebp_pkg::M_ACCESS && !ack_i |=> mst_state_reg == ebp_pkg::M_ACCESS
      && bank_select_lines_n_o == $past(bank_select_lines_n_o))
    else $error("access ended while acknowledge low");

  a_bank_release: assert property (@(posedge ref_clk) disable iff (rst)
    s_finish |=> bank_n_reg == ebp_pkg::BANK_IDLE_N && rd_n_reg && wr_n_reg && mst_done)
    else $error("select not released after acknowledge");

  a_slave_ack: assert property (@(posedge ref_clk) disable iff (rst)
    iop_req && slv_sync_reg |-> ack_oe && !ack_o)
    else $error("no wait state during register access");

  a_ack_ends: assert property (@(posedge ref_clk) disable iff (rst)
    slv_state_reg == ebp_pkg::S_WAIT && iop_ready |=> !ack_oe)
    else $error("wait state kept after register answer");

  a_track_bank: assert property (@(posedge ref_clk) disable iff (rst)
    !bus_master |=> tracked_bank_n == $past(bank_select_lines_n_i))
    else $error("selects not tracked");

  a_sync_delay: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(rd_n_i) ##1 !rd_n_i |=> !rd_sync_reg)
    else $error("read strobe synchroniser depth wrong");

endmodule

// ==== src/ebp_pkg.sv ====
/*
 * constants, states and decode helpers of the external bus port.
 * assumes one 100 MHz reference clock and an arbiter outside that grants mastership.
 */
package ebp_pkg;
  // ****************************************
  // widths and decode
  // ****************************************
  localparam int ADDR_W     = 24;
  localparam int MADDR_W    = 28;
  localparam int DATA_W     = 48;
  localparam int BANKS      = 4;
  localparam int BANK_LO    = 24;  // 16M-word banks
  localparam int SDBANK_LO  = 26;  // 64M-word banks
  localparam int IOP_W      = 9;   // register space address width
  localparam logic [1:0] IPACK_NOPACK = 2'h1;
  localparam logic [BANKS-1:0] BANK_IDLE_N = 4'hF;
  localparam logic [DATA_W-1:0] UPPER_MASK = 48'hFFFFFFFF0000;
  localparam logic [DATA_W-1:0] LANE1_MASK = 48'h00000000FF00;
  localparam logic [DATA_W-1:0] LANE0_MASK = 48'h0000000000FF;
  localparam int EP_CLK_DIV = 2;   // core cycles per port cycle

  // ****************************************
  // state machines
  // ****************************************
  typedef enum logic [2:0] {
    M_IDLE   = 3'b001,
    M_SETUP  = 3'b010,
    M_ACCESS = 3'b100
  } ebp_mst_state_type;

  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_WAIT = 3'b010,
    S_DONE = 3'b100
  } ebp_slv_state_type;

  // one-hot active-low select of the bank that holds the address
  function automatic logic [BANKS-1:0] bank_decode(input logic [MADDR_W-1:0] a,
                                                   input logic sdram);
    logic [1:0] b;
    b = sdram ? a[SDBANK_LO+:2] : a[BANK_LO+:2];
    bank_decode = ~(4'h1 << b);
  endfunction
endpackage

// ==== tb/ebp_memory_model.sv ====
/*
 * far-side model of the external bus port: one external memory with wait states.
 * assumes the bench resolves the pins; acknowledge is pulled up when idle.
 */
module ebp_memory_model (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [23:0] addr,
  input  wire logic [3:0]  bank_n,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic [47:0] data,
  input  wire logic [3:0]  waits,
  output logic             ack,
  output logic [47:0]      rdata,
  output logic [47:0]      wdata_seen
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************
  // memory behaviour
  // ****************************************
  logic        sel;
  logic [3:0]  cnt_reg;
  logic [47:0] last_reg;
  // selected while a bank select and an active-low strobe are low
  assign sel = (bank_n != 4'hF) && !(rd_n && wr_n);
  // ack held low for the programmed wait states, pull-up otherwise
  assign ack = sel ? (cnt_reg >= waits) : 1'b1;
  // released data shows the inverse of the last driven word
  assign rdata = (sel && !rd_n) ? {addr, addr} : ~last_reg;
  // wait counter, last read word and captured write word
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_reg    <= 4'h0;
      last_reg   <= 48'h0;
      wdata_seen <= 48'h0;
    end else begin
      cnt_reg <= sel ? cnt_reg + 4'h1 : 4'h0;
      if (sel && !rd_n) last_reg <= {addr, addr};
      if (sel && !wr_n && ack) wdata_seen <= data;
    end
  end
endmodule

// ==== tb/external_bus_port_test.sv ====
/*
 * self-checking bench of the external bus port: master accesses, slave register
 * accesses, lanes, suspend and tracking.
 * assumes ebp_pkg and the memory model are compiled first.
 */
module external_bus_port_test;
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************
  // signals and pin resolution
  // ****************************************
  logic        ref_clk, rst, bus_master, link0_enable, link1_enable, sdram_half_rate;
  logic        slave_sync_mode, mst_req, mst_ready, mst_write, mst_sync, mst_sdram;
  logic        mst_done, mst_wide_fetch, iop_req, iop_write, iop_ready, suspend_bus_tristate_n;
  logic        external_address_bus_oe, bank_select_lines_oe, rd_n_o, rd_n_oe, rd_n_i;
  logic        wr_n_o, wr_n_oe, wr_n_i, ack_o, ack_oe, ack_i, host_rd_n, host_wr_n, mem_ack;
  logic [1:0]  instruction_packing_field;
  logic [8:0]  iop_addr;
  logic [3:0]  tracked_bank_n, bank_select_lines_n_o, bank_select_lines_n_i, host_bank, mem_waits;
  logic [23:0] external_address_bus_o, external_address_bus_i, host_addr;
  logic [27:0] mst_addr;
  logic [47:0] mst_wdata, mst_rdata, iop_wdata, iop_rdata, external_data_bus_o, host_data;
  logic [47:0] external_data_bus_oe, external_data_bus_i, mem_rdata, mem_seen;
  int          n_mismatch, samples_checked;
  // each wire takes the driver whose enable is high
  assign external_address_bus_i = external_address_bus_oe ? external_address_bus_o : host_addr;
  assign bank_select_lines_n_i = bank_select_lines_oe ? bank_select_lines_n_o : host_bank;
  assign rd_n_i = rd_n_oe ? rd_n_o : host_rd_n;
  assign wr_n_i = wr_n_oe ? wr_n_o : host_wr_n;
  assign ack_i = ack_oe ? ack_o : mem_ack;
  assign external_data_bus_i = (external_data_bus_oe & external_data_bus_o) |
                               (~external_data_bus_oe & (bus_master ? mem_rdata : host_data));
  ebp_external_bus_port ebp_external_bus_port_inst (.ref_clk, .rst, .bus_master,
    .instruction_packing_field, .link0_enable, .link1_enable, .sdram_half_rate,
    .slave_sync_mode, .mst_req, .mst_ready, .mst_write, .mst_sync, .mst_sdram, .mst_addr,
    .mst_wdata, .mst_done, .mst_rdata, .mst_wide_fetch, .iop_req, .iop_write, .iop_addr,
    .iop_wdata, .iop_ready, .iop_rdata, .tracked_bank_n, .external_address_bus_o,
    .external_address_bus_oe, .external_address_bus_i, .external_data_bus_o,
    .external_data_bus_oe, .external_data_bus_i, .bank_select_lines_n_o,
    .bank_select_lines_oe, .bank_select_lines_n_i, .rd_n_o, .rd_n_oe, .rd_n_i, .wr_n_o,
    .wr_n_oe, .wr_n_i, .ack_o, .ack_oe, .ack_i, .suspend_bus_tristate_n);
  ebp_memory_model ebp_memory_model_inst (.ref_clk, .rst, .addr(external_address_bus_i),
    .bank_n(bank_select_lines_n_i), .rd_n(rd_n_i), .wr_n(wr_n_i),
    .data(external_data_bus_i), .waits(mem_waits), .ack(mem_ack), .rdata(mem_rdata),
    .wdata_seen(mem_seen));
  // ****************************************
  // helpers
  // ****************************************
  // free-running clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic results;
    $display("mismatches %0d of %0d checks", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  // one master access, judged on the pins and at completion
  task automatic master(input logic wr, input logic sd, input logic [27:0] a,
                        input logic [47:0] d, input logic [47:0] lanes, input logic [3:0] w);
    logic [3:0] eb;
    int         n;
    int         low;
    eb = ~(4'h1 << (sd ? a[27:26] : a[25:24]));
    low = 0;
    n = 0;
    @(posedge ref_clk);
    mem_waits <= w;
    mst_req <= 1'b1;
    mst_write <= wr;
    mst_sdram <= sd;
    mst_sync <= (w != 4'h0);
    mst_addr <= a;
    mst_wdata <= d;
    do begin @(negedge ref_clk); n++; end while (mst_ready !== 1'b1 && n < 20);
    if (mst_ready !== 1'b1) begin n_mismatch++; results(); end
    @(posedge ref_clk);
    mst_req <= 1'b0;
    #1;
    chk("address", a[23:0], external_address_bus_o);
    chk("bank select", eb, bank_select_lines_n_o);
    if (wr) chk("data enable", lanes, external_data_bus_oe);
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
      if ((wr ? wr_n_o : rd_n_o) === 1'b0) low++;
    end while (mst_done !== 1'b1 && n < 40);
    if (mst_done !== 1'b1) begin n_mismatch++; results(); end
    chk("strobe low", 1'b1, low > 0);
    chk("wait states", 1'b1, low > w);
    chk("select released", 4'hF, bank_select_lines_n_o);
    if (wr) chk("written word", d & lanes, mem_seen & lanes);
    else chk("read word", {a[23:0], a[23:0]} & lanes, mst_rdata);
  endtask
  // one outside access to the register space
  task automatic slave(input logic wr, input logic [23:0] a, input logic [47:0] d,
                       input logic hit);
    int n;
    n = 0;
    @(posedge ref_clk);
    host_addr <= a;
    host_data <= d;
    host_rd_n <= wr;
    host_wr_n <= !wr;
    do @(negedge ref_clk); while (iop_req !== 1'b1 && ++n < 8);
    chk("register request", hit, iop_req);
    if (hit && iop_req !== 1'b1) results();
    if (hit) begin
      chk("register address", a[8:0], iop_addr);
      chk("register write", wr, iop_write);
      if (wr) chk("register data", d, iop_wdata);
      chk("ack wait", {slave_sync_mode, 1'b0}, {ack_oe, ack_o});
      chk("slave strobes", 3'b000, {rd_n_oe, wr_n_oe, external_address_bus_oe});
      @(posedge ref_clk);
      iop_rdata <= ~d;
      iop_ready <= 1'b1;
      @(posedge ref_clk);
      iop_ready <= 1'b0;
      @(negedge ref_clk);
      chk("ack released", 1'b0, ack_oe);
      if (!wr) chk("slave data", ~d, external_data_bus_o & external_data_bus_oe);
    end
    @(posedge ref_clk);
    host_rd_n <= 1'b1;
    host_wr_n <= 1'b1;
    repeat (5) @(posedge ref_clk);
    #1;
    chk("slave data off", 48'h0, external_data_bus_oe);
  endtask
  // every packing and link combination
  task automatic wide_fetch;
    for (int f = 0; f < 4; f++) begin
      for (int l = 0; l < 4; l++) begin
        @(posedge ref_clk);
        instruction_packing_field <= f[1:0];
        link0_enable <= l[0];
        link1_enable <= l[1];
        #1;
        chk("wide fetch", (f == 1 && l == 0), mst_wide_fetch);
      end
    end
  endtask
  // suspend floats the bus and holds off requests
  task automatic suspend_check;
    @(posedge ref_clk);
    suspend_bus_tristate_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    chk("suspended", 5'h00, {external_address_bus_oe, bank_select_lines_oe, rd_n_oe,
                             wr_n_oe, mst_ready});
    @(posedge ref_clk);
    suspend_bus_tristate_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    chk("resumed", 2'b11, {external_address_bus_oe, mst_ready});
  endtask
  // a non-master follows the selects of the current master
  task automatic track_check;
    @(posedge ref_clk);
    host_bank <= 4'hD;
    repeat (3) @(posedge ref_clk);
    #1;
    chk("tracked selects", 4'hD, tracked_bank_n);
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {rst, bus_master, slave_sync_mode, suspend_bus_tristate_n, host_rd_n, host_wr_n} = 6'h3F;
    {link0_enable, link1_enable, sdram_half_rate, mst_req, mst_write, mst_sync} = 6'h00;
    {mst_sdram, iop_ready} = 2'h0;
    instruction_packing_field = 2'h1;
    mst_addr = 28'h0;
    {mst_wdata, iop_rdata, host_data} = 144'h0;
    {host_bank, mem_waits, host_addr} = 32'hF0000000;
    n_mismatch = 0;
    samples_checked = 0;
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    #1;
    chk("idle pins", 6'h3F, {bank_select_lines_n_o, rd_n_o, wr_n_o});
    link0_enable <= 1'b1;
    master(1'b1, 1'b0, 28'h2000123, 48'h123456789ABC, 48'hFFFFFFFFFF00, 4'h0);
    {link0_enable, link1_enable, sdram_half_rate} <= 3'b011;
    master(1'b0, 1'b1, 28'hC000456, 48'h0, 48'hFFFFFFFF00FF, 4'h3);
    {link1_enable, sdram_half_rate} <= 2'b00;
    master(1'b0, 1'b0, 28'h1ABCDEF, 48'h0, 48'hFFFFFFFFFFFF, 4'h2);
    wide_fetch();
    suspend_check();
    @(posedge ref_clk);
    {bus_master, link0_enable, link1_enable} <= 3'b000;
    slave(1'b0, 24'h000005, 48'hA5A55A5A0F0F, 1'b1);
    slave_sync_mode <= 1'b0;
    slave(1'b1, 24'h00001F, 48'h0123456789AB, 1'b1);
    slave(1'b0, 24'h000200, 48'h0, 1'b0);
    track_check();
    results();
  end
endmodule
